// file: logic/tcw_pkg.sv
// Constants, register map and state types for the trace capture window
package tcw_pkg;

   // ---------------------------------------------------------------
   // Sample ring
   // ---------------------------------------------------------------
   localparam int RING_DEPTH = 256;
   localparam logic [8:0] RING_DEPTH_CNT = 9'h100;
   localparam int SAMPLE_W = 16;
   localparam logic [4:0] BYTES_PER_SAMPLE = 5'h02;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_START = 8'h04;
   localparam logic [7:0] OFS_STOP = 8'h08;
   localparam logic [7:0] OFS_FRAME = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_TRIG_TALLY = 8'h14;
   localparam logic [7:0] OFS_MISS_TALLY = 8'h18;
   localparam logic [7:0] OFS_IRQ_STS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h20;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_HIPRI_BIT = 1;
   localparam int ST_ENABLED = 0;
   localparam int ST_WRITING = 2;
   localparam int ST_READING = 3;
   localparam int ST_READY = 4;
   localparam int ST_TRIG_ACT = 5;
   localparam int ST_OK = 6;
   localparam int ST_ERROR = 7;
   localparam int IRQ_W = 5;
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_MISS = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_DONE = 3;
   localparam int IRQ_SHORT = 4;

   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [15:0] START_RST = 16'h0000;
   localparam logic [15:0] STOP_RST = 16'h0000;
   localparam logic [15:0] START_CONT = 16'h8000;
   localparam logic [4:0] FRAME_RST = 5'h18;
   localparam logic [4:0] FRAME_MIN = 5'h08;
   localparam logic [4:0] FRAME_MAX = 5'h1C;
   localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 5'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int MIN_CYCLE_STD_US = 200;
   localparam int MIN_CYCLE_HI_US = 300;
   localparam int MIN_CYCLE_STD_CYC = MIN_CYCLE_STD_US * CLK_MHZ;
   localparam int MIN_CYCLE_HI_CYC = MIN_CYCLE_HI_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Capture states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CAP_IDLE,
      CAP_ARM,
      CAP_DELAY,
      CAP_RECORD,
      CAP_DONE,
      CAP_CONT
   } tcw_cap_t;

endpackage

// file: logic/tcw_ring.sv
// Circular sample buffer holding pre-trigger history and recorded samples
`timescale 1ns/1ps
`default_nettype none

module tcw_ring (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Control
   input wire logic flush_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [tcw_pkg::SAMPLE_W-1:0] din_i,
   // State
   output logic [tcw_pkg::SAMPLE_W-1:0] dout_o,
   output logic [8:0] count_o,
   output logic full_o,
   output logic empty_o
);

   logic [tcw_pkg::SAMPLE_W-1:0] mem_r [tcw_pkg::RING_DEPTH];
   logic [7:0] wr_r, wr_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic [8:0] cnt_r, cnt_nxt;
   logic do_push;
   logic do_pop;

   // Push into a full ring only when a pop frees a slot in the same cycle
   always_comb begin
      do_pop = pop_i && (cnt_r != 9'h000);
      do_push = push_i && ((cnt_r != tcw_pkg::RING_DEPTH_CNT) || do_pop);
      wr_nxt = do_push ? wr_r + 8'h01 : wr_r;
      rd_nxt = do_pop ? rd_r + 8'h01 : rd_r;
      cnt_nxt = cnt_r + {8'h00, do_push} - {8'h00, do_pop};
      if (flush_i) begin
         wr_nxt = 8'h00;
         rd_nxt = 8'h00;
         cnt_nxt = 9'h000;
      end
   end

   // Pointer registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wr_r <= 8'h00;
         rd_r <= 8'h00;
         cnt_r <= 9'h000;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge ref_clk_i) begin
      if (do_push && !flush_i) begin
         mem_r[wr_r] <= din_i;
      end
   end

   assign dout_o = mem_r[rd_r];
   assign count_o = cnt_r;
   assign full_o = (cnt_r == tcw_pkg::RING_DEPTH_CNT);
   assign empty_o = (cnt_r == 9'h000);

endmodule

`default_nettype wire

// file: logic/tcw_top.sv
// Trace capture window: offset recording around a trigger, AHB-Lite registers, stream out
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Function
// RQ1: Positive start offset delays recording that many samples after the trigger.
// RQ2: Negative start offset begins recording that many samples before the trigger; here at most 256 before, the ring depth.
// RQ3: Start offset -32768 records from enable onward with no stop.
// RQ4: Unsigned 16-bit stop count is measured from the trigger for early starts.
// RQ5: For delayed starts the stop count is measured from recording start.
// RQ6: Acyclic frame size is 8 to 28 bytes, default 24.
// RQ7: Controller sets frame size only at configuration, never while running.
// RQ8: Trace bytes sent per frame scale with the configured frame size.
// RQ9: Bus cycle no shorter than 200 us standard, 300 us high priority.
// RQ10: Sampling is paced only by the sample strobe, not the bus cycle.
// RQ11: Recording happens only while the enable bit 0 is set.
// RQ12: A 16-bit tally counts trigger events since the trace started.
// RQ13: A 16-bit tally counts triggers that could not be recorded.
// RQ14: A circular buffer holds the requested pre-trigger samples; the 256-entry ring here keeps at most the newest 256.
module tcw_top #(
   parameter logic [15:0] MIN_CYCLE_STD = 16'(tcw_pkg::MIN_CYCLE_STD_CYC),
   parameter logic [15:0] MIN_CYCLE_HI = 16'(tcw_pkg::MIN_CYCLE_HI_CYC)
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Sample input
   input wire logic sample_valid_i,
   input wire logic [15:0] sample_data_i,
   input wire logic trigger_i,
   // Trace stream
   input wire logic frame_start_i,
   input wire logic stream_ready_i,
   output logic stream_valid_o,
   output logic [15:0] stream_data_o,
   // Interrupt
   output logic irq_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic ph_r, ph_nxt;
   logic wr_r, wr_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic hready_r, hready_nxt;
   logic en_r, en_nxt;
   logic hipri_r, hipri_nxt;
   logic [15:0] start_r, start_nxt;
   logic [15:0] stop_r, stop_nxt;
   logic [4:0] frame_r, frame_nxt;
   logic [tcw_pkg::IRQ_W-1:0] irq_sts_r, irq_sts_nxt;
   logic [tcw_pkg::IRQ_W-1:0] irq_msk_r, irq_msk_nxt;
   logic irq_r, irq_nxt;
   tcw_pkg::tcw_cap_t state_r, state_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [15:0] remain_r, remain_nxt;
   logic [15:0] trig_tally_r, trig_tally_nxt;
   logic [15:0] miss_tally_r, miss_tally_nxt;
   logic ovf_r, ovf_nxt;
   logic svalid_r, svalid_nxt;
   logic [15:0] sdata_r, sdata_nxt;
   logic [4:0] budget_r, budget_nxt;
   logic [15:0] gap_r, gap_nxt;
   logic acc;
   logic wr_go;
   logic smp;
   logic trig;
   logic ring_push, ring_flush, pop_trim, pop_strm;
   logic [15:0] ring_dout;
   logic [8:0] ring_cnt;
   logic ring_full, ring_empty;
   logic [16:0] start_mag;
   logic [8:0] pre_keep;
   logic [tcw_pkg::IRQ_W-1:0] ev;
   logic [7:0] status;
   logic [4:0] wr_frame;

   // Tallies stop at full scale instead of wrapping back to zero
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   // ---------------------------------------------------------------
   // AHB-Lite slave: one wait state so read data leaves a flip-flop
   // ---------------------------------------------------------------
   always_comb begin
      acc = hsel_i && htrans_i[1] && hready_i;
      wr_go = ph_r && wr_r;
      ph_nxt = acc;
      addr_nxt = acc ? haddr_i[7:0] : addr_r;
      wr_nxt = acc ? hwrite_i : wr_r;
      hready_nxt = !acc;
      hrdata_nxt = hrdata_r;
      if (ph_r && !wr_r) begin
         unique case (addr_r)
            tcw_pkg::OFS_CTRL: hrdata_nxt = {30'h00000000, hipri_r, en_r};
            tcw_pkg::OFS_START: hrdata_nxt = {16'h0000, start_r};
            tcw_pkg::OFS_STOP: hrdata_nxt = {16'h0000, stop_r};
            tcw_pkg::OFS_FRAME: hrdata_nxt = {27'h0000000, frame_r};
            tcw_pkg::OFS_STATUS: hrdata_nxt = {24'h000000, status};
            tcw_pkg::OFS_TRIG_TALLY: hrdata_nxt = {16'h0000, trig_tally_r};
            tcw_pkg::OFS_MISS_TALLY: hrdata_nxt = {16'h0000, miss_tally_r};
            tcw_pkg::OFS_IRQ_STS: hrdata_nxt = {27'h0000000, irq_sts_r};
            tcw_pkg::OFS_IRQ_MSK: hrdata_nxt = {27'h0000000, irq_msk_r};
            default: hrdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ph_r <= 1'b0;
         wr_r <= 1'b0;
         addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         hready_r <= 1'b1;
      end else begin
         ph_r <= ph_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         hrdata_r <= hrdata_nxt;
         hready_r <= hready_nxt;
      end
   end

   assign hrdata_o = hrdata_r;
   assign hreadyout_o = hready_r;
   assign hresp_o = 1'b0;

   // ---------------------------------------------------------------
   // Software registers and interrupt
   // ---------------------------------------------------------------
   always_comb begin
      en_nxt = en_r;
      hipri_nxt = hipri_r;
      start_nxt = start_r;
      stop_nxt = stop_r;
      frame_nxt = frame_r;
      irq_msk_nxt = irq_msk_r;
      wr_frame = (hwdata_i[31:5] != 27'h0000000) ? tcw_pkg::FRAME_MAX : hwdata_i[4:0];
      irq_sts_nxt = irq_sts_r;
      if (wr_go) begin
         unique case (addr_r)
            tcw_pkg::OFS_CTRL: begin
               en_nxt = hwdata_i[tcw_pkg::CTRL_EN_BIT]; // RQ11
               hipri_nxt = hwdata_i[tcw_pkg::CTRL_HIPRI_BIT];
            end
            tcw_pkg::OFS_START: start_nxt = hwdata_i[15:0];
            tcw_pkg::OFS_STOP: stop_nxt = hwdata_i[15:0];
            tcw_pkg::OFS_FRAME: begin
               // Frame size is a configuration value, frozen while tracing
               if (!en_r) begin // RQ7
                  if (wr_frame < tcw_pkg::FRAME_MIN) begin
                     frame_nxt = tcw_pkg::FRAME_MIN; // RQ6
                  end else if (wr_frame > tcw_pkg::FRAME_MAX) begin
                     frame_nxt = tcw_pkg::FRAME_MAX; // RQ6
                  end else begin
                     frame_nxt = wr_frame;
                  end
               end
            end
            tcw_pkg::OFS_IRQ_STS: irq_sts_nxt = irq_sts_r & ~hwdata_i[tcw_pkg::IRQ_W-1:0];
            tcw_pkg::OFS_IRQ_MSK: irq_msk_nxt = hwdata_i[tcw_pkg::IRQ_W-1:0];
            default: irq_sts_nxt = irq_sts_r;
         endcase
      end
      // A new event beats a clear in the same cycle
      irq_sts_nxt = irq_sts_nxt | ev;
      irq_nxt = |(irq_sts_nxt & irq_msk_nxt);
   end

   // Register file
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         en_r <= 1'b0;
         hipri_r <= 1'b0;
         start_r <= tcw_pkg::START_RST;
         stop_r <= tcw_pkg::STOP_RST;
         frame_r <= tcw_pkg::FRAME_RST;
         irq_sts_r <= '0;
         irq_msk_r <= tcw_pkg::IRQ_MSK_RST;
         irq_r <= 1'b0;
      end else begin
         en_r <= en_nxt;
         hipri_r <= hipri_nxt;
         start_r <= start_nxt;
         stop_r <= stop_nxt;
         frame_r <= frame_nxt;
         irq_sts_r <= irq_sts_nxt;
         irq_msk_r <= irq_msk_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign irq_o = irq_r;

   // ---------------------------------------------------------------
   // Capture sequencer and stream
   // ---------------------------------------------------------------
   assign smp = sample_valid_i; // RQ10
   assign trig = sample_valid_i && trigger_i;
   assign start_mag = 17'h00000 - {start_r[15], start_r};
   // History longer than the ring is cut to the ring depth
   assign pre_keep = !start_r[15] ? 9'h000 :
                     (start_mag >= {8'h00, tcw_pkg::RING_DEPTH_CNT}) ? tcw_pkg::RING_DEPTH_CNT : start_mag[8:0];
   assign status = {ovf_r, en_r && !ovf_r, state_r == tcw_pkg::CAP_DELAY, state_r == tcw_pkg::CAP_ARM,
                    svalid_r, (state_r == tcw_pkg::CAP_RECORD) || (state_r == tcw_pkg::CAP_CONT), 1'b0, en_r};

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      remain_nxt = remain_r;
      trig_tally_nxt = trig_tally_r;
      miss_tally_nxt = miss_tally_r;
      ovf_nxt = ovf_r;
      ring_push = 1'b0;
      ring_flush = 1'b0;
      pop_trim = 1'b0;
      ev = '0;
      unique case (state_r)
         tcw_pkg::CAP_IDLE: begin
            if (en_r) begin
               ring_flush = 1'b1;
               trig_tally_nxt = 16'h0000;
               miss_tally_nxt = 16'h0000;
               ovf_nxt = 1'b0;
               state_nxt = (start_r == tcw_pkg::START_CONT) ? tcw_pkg::CAP_CONT : tcw_pkg::CAP_ARM; // RQ3
            end
         end
         tcw_pkg::CAP_ARM: begin
            if (trig) begin
               if (start_r[15] || start_r == 16'h0000) begin
                  ring_push = 1'b1;
                  remain_nxt = stop_r; // RQ4
                  state_nxt = tcw_pkg::CAP_RECORD;
               end else begin
                  cnt_nxt = 16'h0001;
                  state_nxt = tcw_pkg::CAP_DELAY;
               end
            end else if (smp && pre_keep != 9'h000) begin
               // Keep only the newest pre_keep samples before the trigger
               ring_push = 1'b1; // RQ2
               pop_trim = (ring_cnt >= pre_keep); // RQ14
            end
         end
         tcw_pkg::CAP_DELAY: begin
            if (smp) begin
               if (cnt_r == start_r) begin
                  ring_push = 1'b1; // RQ1
                  remain_nxt = stop_r; // RQ5
                  state_nxt = tcw_pkg::CAP_RECORD;
               end else begin
                  cnt_nxt = cnt_r + 16'h0001;
               end
            end
         end
         tcw_pkg::CAP_RECORD: begin
            if (smp) begin
               if (remain_r == 16'h0000) begin
                  ev[tcw_pkg::IRQ_DONE] = 1'b1;
                  state_nxt = tcw_pkg::CAP_DONE;
               end else begin
                  ring_push = 1'b1;
                  remain_nxt = remain_r - 16'h0001;
               end
            end
         end
         tcw_pkg::CAP_DONE: begin
            // Rearm only once the ring is drained, so trimming loses no data
            if (ring_empty) begin
               state_nxt = tcw_pkg::CAP_ARM;
            end
         end
         tcw_pkg::CAP_CONT: begin
            ring_push = smp; // RQ3
         end
         default: state_nxt = tcw_pkg::CAP_IDLE;
      endcase
      // Trigger accounting while tracing
      if (trig && state_r != tcw_pkg::CAP_IDLE && en_r) begin
         trig_tally_nxt = sat_inc(trig_tally_r); // RQ12
         ev[tcw_pkg::IRQ_TRIG] = 1'b1;
         if (state_r != tcw_pkg::CAP_ARM && state_r != tcw_pkg::CAP_CONT) begin
            miss_tally_nxt = sat_inc(miss_tally_r); // RQ13
            ev[tcw_pkg::IRQ_MISS] = 1'b1;
         end
      end
      // Stream pops leave the pre-trigger history alone
      pop_strm = (!svalid_r || stream_ready_i) && !ring_empty && budget_r >= tcw_pkg::BYTES_PER_SAMPLE &&
                 state_r != tcw_pkg::CAP_ARM && !ring_flush;
      if (ring_push && ring_full && !pop_trim && !pop_strm) begin
         ovf_nxt = 1'b1;
         ev[tcw_pkg::IRQ_OVF] = 1'b1;
      end
      if (!en_r) begin
         state_nxt = tcw_pkg::CAP_IDLE; // RQ11
         ring_push = 1'b0;
         // Unclaimed pre-trigger history is dropped, never streamed after disable
         ring_flush = (state_r == tcw_pkg::CAP_ARM);
      end
      svalid_nxt = pop_strm ? 1'b1 : (stream_ready_i ? 1'b0 : svalid_r);
      sdata_nxt = pop_strm ? ring_dout : sdata_r;
      // Budget per frame is the configured acyclic byte count
      budget_nxt = frame_start_i ? frame_r : budget_r; // RQ8
      budget_nxt = pop_strm ? budget_nxt - tcw_pkg::BYTES_PER_SAMPLE : budget_nxt;
      // Frame spacing check against the minimum bus cycle
      gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
      if (frame_start_i) begin
         gap_nxt = 16'h0000;
         ev[tcw_pkg::IRQ_SHORT] = gap_r < (hipri_r ? MIN_CYCLE_HI : MIN_CYCLE_STD); // RQ9
      end
   end

   // Capture and stream registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_r <= tcw_pkg::CAP_IDLE;
         cnt_r <= 16'h0000;
         remain_r <= 16'h0000;
         trig_tally_r <= 16'h0000;
         miss_tally_r <= 16'h0000;
         ovf_r <= 1'b0;
         svalid_r <= 1'b0;
         sdata_r <= 16'h0000;
         budget_r <= 5'h00;
         gap_r <= 16'hFFFF;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         remain_r <= remain_nxt;
         trig_tally_r <= trig_tally_nxt;
         miss_tally_r <= miss_tally_nxt;
         ovf_r <= ovf_nxt;
         svalid_r <= svalid_nxt;
         sdata_r <= sdata_nxt;
         budget_r <= budget_nxt;
         gap_r <= gap_nxt;
      end
   end

   assign stream_valid_o = svalid_r;
   assign stream_data_o = sdata_r;

   // Sample history and record buffer
   tcw_ring u_ring (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .flush_i(ring_flush),
      .push_i(ring_push),
      .pop_i(pop_trim || pop_strm),
      .din_i(sample_data_i),
      .dout_o(ring_dout),
      .count_o(ring_cnt),
      .full_o(ring_full),
      .empty_o(ring_empty)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   delay_start_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ1
      (state_r == tcw_pkg::CAP_RECORD && $past(state_r) == tcw_pkg::CAP_DELAY) |-> $past(cnt_r) == start_r)
      else $error("recording began at the wrong delay");
   pre_history_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ14
      (state_r == tcw_pkg::CAP_ARM && $past(state_r) == tcw_pkg::CAP_ARM) |-> ring_cnt <= pre_keep)
      else $error("pre-trigger history exceeds requested depth");
   neg_trigger_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ2
      (state_r == tcw_pkg::CAP_ARM && en_r && trig && start_r[15]) |=> state_r == tcw_pkg::CAP_RECORD)
      else $error("negative offset did not record from the trigger");
   continuous_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ3
      (state_r == tcw_pkg::CAP_IDLE && en_r && start_r == tcw_pkg::START_CONT) ##1 en_r [*3]
      |-> state_r == tcw_pkg::CAP_CONT)
      else $error("continuous trace stopped while enabled");
   stop_count_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ4 RQ5
      (state_r == tcw_pkg::CAP_RECORD && en_r && smp && remain_r == 16'h0000) |=> state_r == tcw_pkg::CAP_DONE)
      else $error("recording ran past its stop count");
   frame_range_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ6
      frame_r >= tcw_pkg::FRAME_MIN && frame_r <= tcw_pkg::FRAME_MAX)
      else $error("frame size out of range");
   frame_budget_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ8
      frame_start_i |=> budget_r <= $past(frame_r))
      else $error("frame budget exceeds frame size");
   sample_pace_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ10
      $changed(ring_cnt) && $past(ring_push) |-> $past(sample_valid_i))
      else $error("sample stored without a sample strobe");
   enable_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ11
      !en_r |=> state_r == tcw_pkg::CAP_IDLE)
      else $error("capture active while disabled");
   trig_tally_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ12
      (trig && en_r && state_r != tcw_pkg::CAP_IDLE && trig_tally_r != 16'hFFFF)
      |=> trig_tally_r == $past(trig_tally_r) + 16'h0001)
      else $error("trigger tally missed an event");
   miss_tally_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ13
      (trig && en_r && state_r == tcw_pkg::CAP_RECORD && miss_tally_r != 16'hFFFF)
      |=> miss_tally_r == $past(miss_tally_r) + 16'h0001)
      else $error("missed trigger not counted");

endmodule

`default_nettype wire

// file: dv/tcw_sink.sv
// Bus controller model: frame pulses and stream acceptance
`timescale 1ns/1ps
`default_nettype none

module tcw_sink #(
   parameter int GAP = 40
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Stream side
   input wire logic slow_i,
   output logic frame_start_o,
   output logic ready_o
);
   int cnt = 0;
   // Fixed frame spacing, above the bench's standard minimum cycle but below its high one; slow mode stalls half the time
   always @(posedge ref_clk_i) begin
      cnt <= (reset_i || cnt == GAP - 1) ? 0 : cnt + 1;
      frame_start_o <= !reset_i && cnt == GAP - 1;
      ready_o <= !reset_i && (!slow_i || cnt[1]);
   end
endmodule
`default_nettype wire

// file: dv/trace_capture_window_tb_top.sv
// Self-checking bench for the trace capture window
`timescale 1ns/1ps
`default_nettype none

module trace_capture_window_tb_top;
   logic ref_clk_i = 0, reset_i = 1, hsel = 0, hwrite = 0, slow = 0, sv = 0, trig = 0;
   logic [1:0] htrans = 0;
   logic [7:0] haddr = 0;
   logic [31:0] hwdata = 0, hrdata;
   logic [15:0] sd = 0, sdo;
   logic hrdy, hresp, svo, fs, rdy, irq;
   logic [15:0] got[$];
   int error_cnt = 0, compares = 0, fb = 24, fbf = 24, fcnt = 0;

   // Short frame-cycle limits keep the run brief; the high one sits above the sink spacing
   tcw_top #(.MIN_CYCLE_STD(16'h0014), .MIN_CYCLE_HI(16'h0030)) dut (.ref_clk_i(ref_clk_i),
      .reset_i(reset_i), .hsel_i(hsel), .haddr_i({24'h0, haddr}), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
      .hresp_o(hresp), .sample_valid_i(sv), .sample_data_i(sd), .trigger_i(trig), .frame_start_i(fs),
      .stream_ready_i(rdy), .stream_valid_o(svo), .stream_data_o(sdo), .irq_o(irq));
   tcw_sink #(.GAP(40)) sink (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .slow_i(slow),
      .frame_start_o(fs), .ready_o(rdy));

   // 50 MHz clock
   initial forever #10 ref_clk_i = ~ref_clk_i;

   task automatic chk(input logic [31:0] g, e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Single word transfer; waits on hready, no fixed latency assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge ref_clk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge ref_clk_i); while (!hrdy);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk_i); while (!hrdy);
      r = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask

   // One sample every four clocks, unrelated to the frame pulses
   task automatic smp(input logic [15:0] d, input logic t);
      @(posedge ref_clk_i);
      sv <= 1'b1;
      sd <= d;
      trig <= t;
      @(posedge ref_clk_i);
      sv <= 1'b0;
      trig <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
   endtask

   // Wait for n words, then linger to catch surplus ones
   task automatic drain(input int n);
      int k = 0;
      while (got.size() < n && k < 3000) begin
         @(posedge ref_clk_i);
         k++;
      end
      repeat (30) @(posedge ref_clk_i);
      chk(32'(got.size()), 32'(n));
   endtask

   // Words expected from the trigger-relative window
   function automatic int span(input int p, s);
      return (p > 0 ? 0 : -p) + s + 1;
   endfunction

   // Collect accepted words; budget is the frame size latched at the frame pulse
   always @(posedge ref_clk_i) begin
      if (fs) begin
         fcnt = 0;
         fbf = fb;
      end else if (svo && rdy) begin
         fcnt++;
         chk(32'(fcnt <= fbf / 2), 32'h1);
      end
      if (svo && rdy) got.push_back(sdo);
   end

   // Random offset window; second trigger lands while busy, so it must be missed
   task automatic run(input logic s_slow);
      logic [15:0] base;
      int p, s;
      p = $urandom_range(6) - 3;
      s = 1 + $urandom_range(2);
      base = 16'($urandom);
      slow = s_slow;
      fb = 8 + $urandom_range(20);
      got.delete();
      wr(tcw_pkg::OFS_FRAME, 32'(fb));
      wr(tcw_pkg::OFS_START, {16'h0000, 16'(p)});
      wr(tcw_pkg::OFS_STOP, 32'(s));
      wr(tcw_pkg::OFS_CTRL, 32'h1);
      wr(tcw_pkg::OFS_FRAME, 32'h10);
      rd(tcw_pkg::OFS_FRAME, 32'(fb));
      rd(tcw_pkg::OFS_STATUS, 32'h51);
      for (int i = 0; i < 12; i++) smp(base + 16'(i), i == 5 || i == 6);
      drain(span(p, s));
      foreach (got[i]) chk({16'h0, got[i]}, {16'h0, base + 16'(5 + p + i)});
      rd(tcw_pkg::OFS_TRIG_TALLY, 32'h2);
      rd(tcw_pkg::OFS_MISS_TALLY, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(tcw_pkg::OFS_IRQ_STS, 32'h1F);
      wr(tcw_pkg::OFS_CTRL, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic conclude;
      $display("Comparisons %0d, errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      error_cnt++;
      conclude;
   end

   // Main sequence
   initial begin
      void'($urandom(32'h5df9));
      repeat (20) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rd(tcw_pkg::OFS_FRAME, 32'h18);
      rd(tcw_pkg::OFS_START, 32'h0);
      rd(tcw_pkg::OFS_IRQ_MSK, 32'h0);
      rd(8'h40, 32'h0);
      wr(tcw_pkg::OFS_FRAME, 32'h4);
      rd(tcw_pkg::OFS_FRAME, 32'h8);
      wr(tcw_pkg::OFS_FRAME, 32'h1F);
      rd(tcw_pkg::OFS_FRAME, 32'h1C);
      wr(tcw_pkg::OFS_IRQ_MSK, 32'h1);
      for (int i = 0; i < 8; i++) run(i[0]);
      got.delete();
      wr(tcw_pkg::OFS_START, 32'h8000);
      wr(tcw_pkg::OFS_CTRL, 32'h1);
      for (int i = 0; i < 6; i++) smp(16'(100 + i), i == 2);
      drain(6);
      foreach (got[i]) chk({16'h0, got[i]}, 32'(100 + i));
      wr(tcw_pkg::OFS_CTRL, 32'h0);
      got.delete();
      for (int i = 0; i < 4; i++) smp(16'(7 + i), 1'b1);
      drain(0);
      rd(tcw_pkg::OFS_TRIG_TALLY, 32'h1);
      rd(tcw_pkg::OFS_MISS_TALLY, 32'h0);
      wr(tcw_pkg::OFS_IRQ_STS, 32'h1F);
      repeat (90) @(posedge ref_clk_i);
      rd(tcw_pkg::OFS_IRQ_STS, 32'h0);
      wr(tcw_pkg::OFS_CTRL, 32'h2);
      repeat (90) @(posedge ref_clk_i);
      rd(tcw_pkg::OFS_IRQ_STS, 32'h10);
      conclude;
   end
endmodule
`default_nettype wire
